// ---- pfs_pkg.sv ----
// Constants, register map and state layout of the port pin function select block.
// Assumes an APB master on the system clock and pad cells resolved outside.
//
// Overview of operation
// RULE1 - Pin 3 of port A acts as port, serial 1 receive, address bit 3 or interrupt request 1.
// RULE2 - Pin 2 acts as port, serial 0 clock, interrupt request 0, address bit 2 or disable request 2.
// RULE3 - Pin 1 acts as port, serial 0 transmit, address bit 1 or output-disable request 1.
// RULE4 - Pin 0 acts as port, serial 0 receive, address bit 0 or output-disable request 0.
// RULE5 - Bits 15, 11, 7 and 3 of the port A function register read as zero and take zero.
// RULE6 - Each port A field top bit resets to one when booting external with ROM off, else zero; code resets it to zero, sets it on the first enabled edge.
// RULE7 - Software picks the address code only in the external-extension modes.
// RULE8 - Port B direction bits 7 to 0 make pins 7 to 0 outputs when one, inputs when zero.
// RULE9 - A port B direction bit acts only while its pin has the general port function.
// RULE10 - In the reduced variant, direction bits 1 and 0 of port B have no effect.
// RULE11 - Bits 15 to 8 of the port B direction register read as zero and take zero.
// RULE12 - The port B direction register resets to zero, so port B starts as inputs.
// RULE13 - Port B has two 16-bit read/write function select registers.
// RULE14 - Each pad takes value and enable from the selected source; inputs go to that user. Code routes no port B pad input to the alternate users.

package pfs_pkg;

   // ----------------------------------------
   // Register map (byte addresses)
   // ----------------------------------------
   localparam logic [7:0] OFS_PA_FSEL = 8'h00;
   localparam logic [7:0] OFS_PB_DIR = 8'h04;
   localparam logic [7:0] OFS_PB_FSEL1 = 8'h08;
   localparam logic [7:0] OFS_PB_FSEL2 = 8'h0c;
   localparam logic [7:0] OFS_STATUS = 8'h10;

   // ----------------------------------------
   // Field layout and reset values
   // ----------------------------------------
   localparam int FIELD_STRIDE = 4;
   localparam int FIELD_W = 3;
   localparam logic [15:0] PA_FSEL_MASK = 16'h7777;
   localparam logic [15:0] PA_BOOT_EXT_MASK = 16'h4444;
   localparam logic [15:0] PB_DIR_MASK = 16'h00ff;
   localparam logic [15:0] PB_FSEL1_MASK = 16'h7700;
   localparam logic [15:0] PB_FSEL2_MASK = 16'h7777;
   localparam logic [15:0] PA_FSEL_RST = 16'h0000;
   localparam logic [15:0] PB_DIR_RST = 16'h0000;
   localparam logic [15:0] PB_FSEL_RST = 16'h0000;
   localparam logic [7:0] PB_REDUCED_MASK = 8'h03;

   // ----------------------------------------
   // Function codes
   // ----------------------------------------
   localparam logic [2:0] FN_PORT = 3'h0;
   localparam logic [2:0] FN_SERIAL = 3'h1;
   localparam logic [2:0] FN_IRQ_PIN2 = 3'h3;
   localparam logic [2:0] FN_ADDR = 3'h4;
   localparam logic [2:0] FN_ALT7 = 3'h7;

   typedef struct packed {
      logic [15:0] pa_fsel;
      logic [15:0] pb_dir;
      logic [15:0] pb_fsel1;
      logic [15:0] pb_fsel2;
      logic boot_done;
      logic pready;
      logic pslverr;
      logic [31:0] prdata;
      logic [3:0] pa_out;
      logic [3:0] pa_oe;
      logic [3:0] pa_gpio_in;
      logic [7:0] pb_out;
      logic [7:0] pb_oe;
      logic [7:0] pb_gpio_in;
      logic ser1_rx;
      logic ser0_rx;
      logic ser0_clk_in;
      logic [1:0] irq_n;
      logic [2:0] poe_n;
   } pfs_state_t;

endpackage

// ---- pfs_pb_pin_cell.sv ----
// One port B pad cell: chooses between general port and alternate drive.
// Assumes the caller registers the results before they reach the pad.
`timescale 1ns/1ps

module pfs_pb_pin_cell (
   input wire logic is_port_i,
   input wire logic dir_i,
   input wire logic dir_block_i,
   input wire logic gpio_out_i,
   input wire logic alt_out_i,
   input wire logic alt_oe_i,
   output logic pad_out_o,
   output logic pad_oe_o
);

   always_comb begin
      if (is_port_i) begin
         pad_out_o = gpio_out_i;
         pad_oe_o = dir_i & ~dir_block_i; // RULE8 RULE9 RULE10
      end else begin
         pad_out_o = alt_out_i;
         pad_oe_o = alt_oe_i; // RULE14
      end
   end

endmodule

// ---- pfs_port_pin_function_select.sv ----
// Pin function select for port A pins 3..0 and port B direction/function.
// Assumes an APB master on clk_sys_i and peripherals on the same clock.
//
// The APB interface to the registers and the address map were decided locally.
`timescale 1ns/1ps

module pfs_port_pin_function_select #(
   parameter bit REDUCED_VARIANT = 1'b0
) (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic ce_i,
   // APB slave
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic [31:0] pwdata_i,
   input wire logic [3:0] pstrb_i,
   output logic pready_o,
   output logic [31:0] prdata_o,
   output logic pslverr_o,
   // Boot strap: external-extension mode with on-chip ROM off
   input wire logic boot_ext_rom_off_i,
   // Port A pads and users
   input wire logic [3:0] pad_a_in_i,
   output logic [3:0] pad_a_out_o,
   output logic [3:0] pad_a_oe_o,
   input wire logic [3:0] port_a_gpio_out_i,
   input wire logic [3:0] port_a_gpio_oe_i,
   output logic [3:0] port_a_gpio_in_o,
   input wire logic [3:0] bus_addr_i,
   input wire logic serial0_transmit_i,
   input wire logic serial0_clock_out_i,
   input wire logic serial0_clock_oe_i,
   output logic serial0_clock_in_o,
   output logic serial0_receive_o,
   output logic serial1_receive_o,
   output logic [1:0] interrupt_request_n_o,
   output logic [2:0] output_disable_request_n_o,
   // Port B pads and users
   input wire logic [7:0] pad_b_in_i,
   output logic [7:0] pad_b_out_o,
   output logic [7:0] pad_b_oe_o,
   input wire logic [7:0] port_b_gpio_out_i,
   output logic [7:0] port_b_gpio_in_o,
   input wire logic [7:0] port_b_alt_out_i,
   input wire logic [7:0] port_b_alt_oe_i
);

   // ----------------------------------------
   // Local signals
   // ----------------------------------------
   pfs_pkg::pfs_state_t s_ff;
   pfs_pkg::pfs_state_t nxt_s;
   logic [7:0] pb_is_port;
   logic [7:0] pb_out_c;
   logic [7:0] pb_oe_c;
   logic [7:0] pb_dir_block;

   // ----------------------------------------
   // Port B pad cells
   // ----------------------------------------
   // Unbonded pins in the reduced variant must never drive
   assign pb_dir_block = REDUCED_VARIANT ? pfs_pkg::PB_REDUCED_MASK : 8'h00; // RULE10

   genvar gi;
   generate
      for (gi = 0; gi < 8; gi++) begin : g_pb
         // Pins 1 and 0 have no field here; their reserved bits read 000 = port
         if (gi >= 4) begin : g_hi
            assign pb_is_port[gi] = s_ff.pb_fsel2[pfs_pkg::FIELD_STRIDE * (gi - 4) +:
               pfs_pkg::FIELD_W] == pfs_pkg::FN_PORT; // RULE9
         end else begin : g_lo
            assign pb_is_port[gi] = s_ff.pb_fsel1[pfs_pkg::FIELD_STRIDE * gi +:
               pfs_pkg::FIELD_W] == pfs_pkg::FN_PORT; // RULE9
         end
         pfs_pb_pin_cell u_cell (
            .is_port_i(pb_is_port[gi]),
            .dir_i(s_ff.pb_dir[gi]),
            .dir_block_i(pb_dir_block[gi]),
            .gpio_out_i(port_b_gpio_out_i[gi]),
            .alt_out_i(port_b_alt_out_i[gi]),
            .alt_oe_i(port_b_alt_oe_i[gi]),
            .pad_out_o(pb_out_c[gi]),
            .pad_oe_o(pb_oe_c[gi])
         );
      end
   endgenerate

   // ----------------------------------------
   // Next-state logic
   // ----------------------------------------
   always_comb begin
      logic acc;
      logic [31:0] rd;
      logic mapped;
      logic [15:0] wmask;
      logic [15:0] wd;
      logic [2:0] c3;
      logic [2:0] c2;
      logic [2:0] c1;
      logic [2:0] c0;
      nxt_s = s_ff;
      acc = psel_i & penable_i;
      rd = 32'h0000_0000;
      mapped = 1'b1;
      wmask = {{8{pstrb_i[1]}}, {8{pstrb_i[0]}}};
      wd = pwdata_i[15:0];
      // Field codes of port A pins 3 to 0
      c3 = s_ff.pa_fsel[pfs_pkg::FIELD_STRIDE * 3 +: pfs_pkg::FIELD_W];
      c2 = s_ff.pa_fsel[pfs_pkg::FIELD_STRIDE * 2 +: pfs_pkg::FIELD_W];
      c1 = s_ff.pa_fsel[pfs_pkg::FIELD_STRIDE * 1 +: pfs_pkg::FIELD_W];
      c0 = s_ff.pa_fsel[pfs_pkg::FIELD_STRIDE * 0 +: pfs_pkg::FIELD_W];

      // ----------------------------------------
      // Boot strap capture
      // ----------------------------------------
      // Strap is caught on the first enabled edge after reset release
      // Sampled once, so a strap that moves later cannot rewrite the codes
      if (!s_ff.boot_done) begin
         nxt_s.boot_done = 1'b1;
         if (boot_ext_rom_off_i) begin
            nxt_s.pa_fsel = s_ff.pa_fsel | pfs_pkg::PA_BOOT_EXT_MASK; // RULE6
         end
      end

      // ----------------------------------------
      // Register read data
      // ----------------------------------------
      // APB: one wait state, so prdata and pready both leave flip-flops
      case (paddr_i)
         pfs_pkg::OFS_PA_FSEL: rd = {16'h0000, s_ff.pa_fsel};
         pfs_pkg::OFS_PB_DIR: rd = {16'h0000, s_ff.pb_dir};
         pfs_pkg::OFS_PB_FSEL1: rd = {16'h0000, s_ff.pb_fsel1}; // RULE13
         pfs_pkg::OFS_PB_FSEL2: rd = {16'h0000, s_ff.pb_fsel2}; // RULE13
         // Status: strap captured and variant flag, read only
         pfs_pkg::OFS_STATUS: rd = {30'h0, REDUCED_VARIANT, s_ff.boot_done};
         default: mapped = 1'b0;
      endcase

      // ----------------------------------------
      // APB handshake and register writes
      // ----------------------------------------
      if (acc && !s_ff.pready) begin
         nxt_s.pready = 1'b1;
         // Writes answer zero so no stale read data shows on the bus
         nxt_s.prdata = pwrite_i ? 32'h0000_0000 : rd;
         nxt_s.pslverr = ~mapped;
      end else if (acc && s_ff.pready) begin
         nxt_s.pready = 1'b0;
         nxt_s.pslverr = 1'b0;
         if (pwrite_i && mapped) begin
            case (paddr_i)
               pfs_pkg::OFS_PA_FSEL: nxt_s.pa_fsel = (nxt_s.pa_fsel & ~wmask) |
                  (wd & wmask & pfs_pkg::PA_FSEL_MASK); // RULE5
               pfs_pkg::OFS_PB_DIR: nxt_s.pb_dir = (s_ff.pb_dir & ~wmask) |
                  (wd & wmask & pfs_pkg::PB_DIR_MASK); // RULE11
               pfs_pkg::OFS_PB_FSEL1: nxt_s.pb_fsel1 = (s_ff.pb_fsel1 & ~wmask) |
                  (wd & wmask & pfs_pkg::PB_FSEL1_MASK); // RULE13
               pfs_pkg::OFS_PB_FSEL2: nxt_s.pb_fsel2 = (s_ff.pb_fsel2 & ~wmask) |
                  (wd & wmask & pfs_pkg::PB_FSEL2_MASK); // RULE13
               // Status is read only; a write to it is dropped
               default: nxt_s.pb_dir = s_ff.pb_dir;
            endcase
         end
      end else begin
         // A master that drops the access early must not leave pready stuck
         nxt_s.pready = 1'b0;
         nxt_s.pslverr = 1'b0;
      end

      // ----------------------------------------
      // Port A pin routing
      // ----------------------------------------
      // Prohibited codes leave the pad an idle input
      nxt_s.pa_out = 4'h0;
      nxt_s.pa_oe = 4'h0;
      nxt_s.pa_gpio_in = 4'h0;
      // Unrouted inputs rest at their inactive high level
      nxt_s.ser1_rx = 1'b1;
      nxt_s.ser0_rx = 1'b1;
      nxt_s.ser0_clk_in = 1'b1;
      nxt_s.irq_n = 2'h3;
      nxt_s.poe_n = 3'h7;

      // The address code is honoured in every mode; software keeps it out of single-chip
      case (c3)
         pfs_pkg::FN_PORT: begin
            nxt_s.pa_out[3] = port_a_gpio_out_i[3];
            nxt_s.pa_oe[3] = port_a_gpio_oe_i[3];
            nxt_s.pa_gpio_in[3] = pad_a_in_i[3];
         end
         pfs_pkg::FN_SERIAL: nxt_s.ser1_rx = pad_a_in_i[3]; // RULE1
         pfs_pkg::FN_ADDR: begin
            nxt_s.pa_out[3] = bus_addr_i[3]; // RULE1 RULE7
            nxt_s.pa_oe[3] = 1'b1;
         end
         pfs_pkg::FN_ALT7: nxt_s.irq_n[1] = pad_a_in_i[3]; // RULE1
         default: nxt_s.pa_oe[3] = 1'b0;
      endcase

      case (c2)
         pfs_pkg::FN_PORT: begin
            nxt_s.pa_out[2] = port_a_gpio_out_i[2];
            nxt_s.pa_oe[2] = port_a_gpio_oe_i[2];
            nxt_s.pa_gpio_in[2] = pad_a_in_i[2];
         end
         pfs_pkg::FN_SERIAL: begin
            nxt_s.pa_out[2] = serial0_clock_out_i; // RULE2
            nxt_s.pa_oe[2] = serial0_clock_oe_i;
            nxt_s.ser0_clk_in = pad_a_in_i[2];
         end
         pfs_pkg::FN_IRQ_PIN2: nxt_s.irq_n[0] = pad_a_in_i[2]; // RULE2
         pfs_pkg::FN_ADDR: begin
            nxt_s.pa_out[2] = bus_addr_i[2]; // RULE2
            nxt_s.pa_oe[2] = 1'b1;
         end
         pfs_pkg::FN_ALT7: nxt_s.poe_n[2] = pad_a_in_i[2]; // RULE2
         default: nxt_s.pa_oe[2] = 1'b0;
      endcase

      case (c1)
         pfs_pkg::FN_PORT: begin
            nxt_s.pa_out[1] = port_a_gpio_out_i[1];
            nxt_s.pa_oe[1] = port_a_gpio_oe_i[1];
            nxt_s.pa_gpio_in[1] = pad_a_in_i[1];
         end
         pfs_pkg::FN_SERIAL: begin
            nxt_s.pa_out[1] = serial0_transmit_i; // RULE3
            nxt_s.pa_oe[1] = 1'b1;
         end
         pfs_pkg::FN_ADDR: begin
            nxt_s.pa_out[1] = bus_addr_i[1]; // RULE3
            nxt_s.pa_oe[1] = 1'b1;
         end
         pfs_pkg::FN_ALT7: nxt_s.poe_n[1] = pad_a_in_i[1]; // RULE3
         default: nxt_s.pa_oe[1] = 1'b0;
      endcase

      case (c0)
         pfs_pkg::FN_PORT: begin
            nxt_s.pa_out[0] = port_a_gpio_out_i[0];
            nxt_s.pa_oe[0] = port_a_gpio_oe_i[0];
            nxt_s.pa_gpio_in[0] = pad_a_in_i[0];
         end
         pfs_pkg::FN_SERIAL: nxt_s.ser0_rx = pad_a_in_i[0]; // RULE4
         pfs_pkg::FN_ADDR: begin
            nxt_s.pa_out[0] = bus_addr_i[0]; // RULE4
            nxt_s.pa_oe[0] = 1'b1;
         end
         pfs_pkg::FN_ALT7: nxt_s.poe_n[0] = pad_a_in_i[0]; // RULE4
         default: nxt_s.pa_oe[0] = 1'b0;
      endcase

      // ----------------------------------------
      // Port B pad results
      // ----------------------------------------
      // Port B: pad drive from the cells, inputs only seen in port mode
      nxt_s.pb_out = pb_out_c; // RULE14
      nxt_s.pb_oe = pb_oe_c; // RULE8
      nxt_s.pb_gpio_in = pad_b_in_i & pb_is_port;
   end

   // ----------------------------------------
   // State register
   // ----------------------------------------
   always_ff @(posedge clk_sys_i or negedge nrst_i) begin
      if (!nrst_i) begin
         // Peripheral inputs rest at their inactive high level through reset
         s_ff <= '0;
         s_ff.pa_fsel <= pfs_pkg::PA_FSEL_RST;
         s_ff.pb_dir <= pfs_pkg::PB_DIR_RST; // RULE12
         s_ff.pb_fsel1 <= pfs_pkg::PB_FSEL_RST;
         s_ff.pb_fsel2 <= pfs_pkg::PB_FSEL_RST;
         s_ff.ser1_rx <= 1'b1;
         s_ff.ser0_rx <= 1'b1;
         s_ff.ser0_clk_in <= 1'b1;
         s_ff.irq_n <= 2'h3;
         s_ff.poe_n <= 3'h7;
      end else if (ce_i) begin
         s_ff <= nxt_s;
      end
   end

   // ----------------------------------------
   // Outputs
   // ----------------------------------------
   // Pads and peripherals see registered values only
   assign pready_o = s_ff.pready;
   assign prdata_o = s_ff.prdata;
   assign pslverr_o = s_ff.pslverr;
   assign pad_a_out_o = s_ff.pa_out;
   assign pad_a_oe_o = s_ff.pa_oe;
   assign port_a_gpio_in_o = s_ff.pa_gpio_in;
   assign serial0_clock_in_o = s_ff.ser0_clk_in;
   assign serial0_receive_o = s_ff.ser0_rx;
   assign serial1_receive_o = s_ff.ser1_rx;
   assign interrupt_request_n_o = s_ff.irq_n;
   assign output_disable_request_n_o = s_ff.poe_n;
   assign pad_b_out_o = s_ff.pb_out;
   assign pad_b_oe_o = s_ff.pb_oe;
   assign port_b_gpio_in_o = s_ff.pb_gpio_in;

endmodule

// ---- pfs_far_model.sv ----
// Far-side model: pads and on-chip peripherals around the pin mux.
// Assumes the bench sets a pattern; every source is a fixed mix of it.
`timescale 1ns/1ps
module pfs_far_model (
   input wire logic [7:0] pat_i,
   output logic [3:0] pad_a_o,
   output logic [3:0] a_gout_o,
   output logic [3:0] a_goe_o,
   output logic [3:0] baddr_o,
   output logic tx_o,
   output logic sck_o,
   output logic sck_oe_o,
   output logic [7:0] pad_b_o,
   output logic [7:0] b_gout_o,
   output logic [7:0] b_alt_o,
   output logic [7:0] b_aoe_o
);
   // Mixed from one pattern; tx_o, sck_oe_o and pad_b_o[3:0] repeat pad_a_o bits
   assign pad_a_o = pat_i[3:0];
   assign a_gout_o = pat_i[7:4];
   assign a_goe_o = ~pat_i[5:2];
   assign baddr_o = ~pat_i[7:4];
   assign tx_o = pat_i[0];
   assign sck_o = ~pat_i[1];
   assign sck_oe_o = pat_i[2];
   assign pad_b_o = pat_i;
   assign b_gout_o = ~pat_i;
   assign b_alt_o = {pat_i[3:0], pat_i[7:4]};
   assign b_aoe_o = pat_i ^ 8'h3c;
endmodule

// ---- pfs_port_pin_function_select_properties.sv ----
// Checker on the ports of the pin function select block.
// Assumes an APB master that holds each request until pready.
`timescale 1ns/1ps
module pfs_pins_checker (
   input wire logic clk_sys_i,
   input wire logic nrst_i,
   input wire logic psel_i,
   input wire logic penable_i,
   input wire logic pwrite_i,
   input wire logic [7:0] paddr_i,
   input wire logic pready_o,
   input wire logic [31:0] prdata_o,
   input wire logic pslverr_o,
   input wire logic [3:0] pad_a_in_i,
   input wire logic [3:0] pad_a_oe_o,
   input wire logic serial0_receive_o,
   input wire logic [1:0] interrupt_request_n_o,
   input wire logic [2:0] output_disable_request_n_o,
   input wire logic [7:0] pad_b_oe_o,
   input wire logic [7:0] pad_b_out_o,
   input wire logic [7:0] port_b_gpio_out_i,
   input wire logic [7:0] port_b_alt_oe_i
);
   default clocking @(posedge clk_sys_i); endclocking
   default disable iff (!nrst_i);
   property p_rd_pa;
      psel_i && pready_o && !pwrite_i && paddr_i == 8'h00 |-> (prdata_o & 32'hffff8888) == 0;
   endproperty
   a_rd_pa: assert property (p_rd_pa) else $error("reserved port A bits read nonzero");
   property p_rd_pb;
      psel_i && pready_o && !pwrite_i && paddr_i == 8'h04 |-> prdata_o[31:8] == 24'h0;
   endproperty
   a_rd_pb: assert property (p_rd_pb) else $error("reserved direction bits read nonzero");
   property p_interrupt_request_1;
      !interrupt_request_n_o[1] |-> !$past(pad_a_in_i[3]);
   endproperty
   a_interrupt_request_1: assert property (p_interrupt_request_1) else $error("pin 3 request without low pad");
   property p_pin2;
      !output_disable_request_n_o[2] |-> interrupt_request_n_o[0] && !$past(pad_a_in_i[2]);
   endproperty
   a_pin2: assert property (p_pin2) else $error("pin 2 routed to two users");
   property p_pin1;
      !output_disable_request_n_o[1] |-> !pad_a_oe_o[1] && !$past(pad_a_in_i[1]);
   endproperty
   a_pin1: assert property (p_pin1) else $error("pin 1 input driven");
   property p_pin0;
      !serial0_receive_o |-> output_disable_request_n_o[0] && !$past(pad_a_in_i[0]);
   endproperty
   a_pin0: assert property (p_pin0) else $error("pin 0 receive wrong");
   property p_pb_port;
      pad_b_oe_o[7] && !$past(port_b_alt_oe_i[7]) |-> pad_b_out_o[7] == $past(port_b_gpio_out_i[7]);
   endproperty
   a_pb_port: assert property (p_pb_port) else $error("port B pin 7 drive wrong");
   property p_pb0;
      pad_b_oe_o[0] |-> pad_b_out_o[0] == $past(port_b_gpio_out_i[0]);
   endproperty
   a_pb0: assert property (p_pb0) else $error("port B pin 0 drive wrong");
   property p_rst;
      $rose(nrst_i) |-> pad_b_oe_o == 8'h00 ##1 pad_b_oe_o == 8'h00;
   endproperty
   a_rst: assert property (p_rst) else $error("port B not input after reset");
   property p_ans;
      psel_i && penable_i && !pready_o |=> pready_o;
   endproperty
   a_ans: assert property (p_ans) else $error("no answer after one wait state");
   c_wr: cover property (psel_i && pready_o && pwrite_i);
   c_err: cover property (pready_o && pslverr_o);
   c_irq: cover property (!interrupt_request_n_o[1]);
endmodule
bind pfs_port_pin_function_select pfs_pins_checker i_chk (.clk_sys_i, .nrst_i, .psel_i,
   .penable_i, .pwrite_i, .paddr_i, .pready_o, .prdata_o, .pslverr_o, .pad_a_in_i, .pad_a_oe_o,
   .serial0_receive_o, .interrupt_request_n_o, .output_disable_request_n_o, .pad_b_oe_o,
   .pad_b_out_o, .port_b_gpio_out_i, .port_b_alt_oe_i);

// ---- pfs_port_pin_function_select_test.sv ----
// Bench of the port pin function select block over APB.
// Assumes the package, far-side model and checker are compiled first.
`timescale 1ns/1ps
`define CHK(g, e) begin tests_run++; if ((g) !== (e)) begin failures++; \
$display("unexpected t=%0t got %h exp %h", $time, g, e); end end
module pfs_port_pin_function_select_test;
   logic clk = 0, nrst = 0, strap = 0, psel = 0, pen = 0, pwr = 0, err;
   logic [7:0] padr = 8'h00, pat = 8'h00;
   logic [31:0] pwd = 32'h0, rd, prd;
   int failures = 0, tests_run = 0;
   wire logic [3:0] pa_in, a_go, a_goe, baddr, a_oe, a_out, a_gin;
   wire logic tx, sco, scoe, serial_channel, rx0, rx1, rdy, serr;
   wire logic [1:0] irq;
   wire logic [2:0] output_disable_unit;
   wire logic [7:0] pb_in, b_go, b_ao, b_aoe, b_oe, b_out, b_gin, b_oe_red;
   logic [2:0] codes [5] = '{3'h0, 3'h1, 3'h3, 3'h4, 3'h7};
   logic [7:0] adr [4] = '{8'h00, 8'h04, 8'h08, 8'h0c};
   logic [31:0] msk [4] = '{32'h7777, 32'h00ff, 32'h7700, 32'h7777};
   pfs_far_model i_far (.pat_i(pat), .pad_a_o(pa_in), .a_gout_o(a_go), .a_goe_o(a_goe),
      .baddr_o(baddr), .tx_o(tx), .sck_o(sco), .sck_oe_o(scoe), .pad_b_o(pb_in),
      .b_gout_o(b_go), .b_alt_o(b_ao), .b_aoe_o(b_aoe));
   pfs_port_pin_function_select i_dut (.clk_sys_i(clk), .nrst_i(nrst), .ce_i(1'b1),
      .psel_i(psel), .penable_i(pen), .pwrite_i(pwr), .paddr_i(padr), .pwdata_i(pwd),
      .pstrb_i(4'hf), .pready_o(rdy), .prdata_o(prd), .pslverr_o(serr),
      .boot_ext_rom_off_i(strap), .pad_a_in_i(pa_in), .pad_a_out_o(a_out), .pad_a_oe_o(a_oe),
      .port_a_gpio_out_i(a_go), .port_a_gpio_oe_i(a_goe), .port_a_gpio_in_o(a_gin),
      .bus_addr_i(baddr), .serial0_transmit_i(tx), .serial0_clock_out_i(sco),
      .serial0_clock_oe_i(scoe), .serial0_clock_in_o(serial_channel), .serial0_receive_o(rx0),
      .serial1_receive_o(rx1), .interrupt_request_n_o(irq), .output_disable_request_n_o(output_disable_unit),
      .pad_b_in_i(pb_in), .pad_b_out_o(b_out), .pad_b_oe_o(b_oe), .port_b_gpio_out_i(b_go),
      .port_b_gpio_in_o(b_gin), .port_b_alt_out_i(b_ao), .port_b_alt_oe_i(b_aoe));
   // Reduced variant shares every input; only its port B enables are compared
   pfs_port_pin_function_select #(.REDUCED_VARIANT(1'b1)) i_dut_red (.clk_sys_i(clk),
      .nrst_i(nrst), .ce_i(1'b1), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
      .paddr_i(padr), .pwdata_i(pwd), .pstrb_i(4'hf), .pready_o(), .prdata_o(),
      .pslverr_o(), .boot_ext_rom_off_i(strap), .pad_a_in_i(pa_in), .pad_a_out_o(),
      .pad_a_oe_o(), .port_a_gpio_out_i(a_go), .port_a_gpio_oe_i(a_goe),
      .port_a_gpio_in_o(), .bus_addr_i(baddr), .serial0_transmit_i(tx),
      .serial0_clock_out_i(sco), .serial0_clock_oe_i(scoe), .serial0_clock_in_o(),
      .serial0_receive_o(), .serial1_receive_o(), .interrupt_request_n_o(),
      .output_disable_request_n_o(), .pad_b_in_i(pb_in), .pad_b_out_o(),
      .pad_b_oe_o(b_oe_red), .port_b_gpio_out_i(b_go), .port_b_gpio_in_o(),
      .port_b_alt_out_i(b_ao), .port_b_alt_oe_i(b_aoe));
   initial begin
      forever #2 clk = ~clk;
   end
   task test_done;
      $display("comparisons %0d mismatches %0d", tests_run, failures);
      if (failures == 0 && tests_run > 0) $display("NO MISMATCHES");
      else $display("MISMATCHES SEEN");
      $finish;
   endtask
   task apb(input logic w, input logic [7:0] a, input logic [31:0] d);
      int n;
      @(posedge clk);
      psel <= 1'b1;
      pen <= 1'b0;
      pwr <= w;
      padr <= a;
      pwd <= d;
      @(posedge clk);
      pen <= 1'b1;
      n = 0;
      do begin
         @(posedge clk);
         n++;
      end while (rdy !== 1'b1 && n < 20);
      if (rdy !== 1'b1) begin
         failures++;
         test_done();
      end
      rd = prd;
      err = serr;
      psel <= 1'b0;
      pen <= 1'b0;
   endtask
   task rdc(input logic [7:0] a, input logic [31:0] e);
      apb(1'b0, a, 32'h0);
      `CHK(rd, e)
   endtask
   // Pattern settles, then two edges for the registered pins
   task settle(input logic [7:0] p);
      @(posedge clk);
      pat <= p;
      repeat (2) @(posedge clk);
      #1;
   endtask
   task chk_a(input logic [2:0] c);
      logic [3:0] oe, out, gi;
      logic si, r0, r1;
      logic [1:0] iq;
      logic [2:0] pe;
      oe = 4'h0;
      out = 4'h0;
      gi = 4'h0;
      si = 1'b1;
      r0 = 1'b1;
      r1 = 1'b1;
      iq = 2'b11;
      pe = 3'b111;
      case (c)
         3'h0: begin
            oe = a_goe;
            out = a_go;
            gi = pa_in;
         end
         3'h1: begin
            oe = {1'b0, scoe, 2'b10};
            out = {1'b0, sco, tx, 1'b0};
            si = pa_in[2];
            r0 = pa_in[0];
            r1 = pa_in[3];
         end
         3'h3: iq[0] = pa_in[2];
         3'h4: begin
            oe = 4'hf;
            out = baddr;
         end
         default: begin
            iq[1] = pa_in[3];
            pe = pa_in[2:0];
         end
      endcase
      `CHK({a_oe, a_out & a_oe, a_gin}, {oe, out & oe, gi})
      `CHK({serial_channel, rx0, rx1, irq, output_disable_unit}, {si, r0, r1, iq, pe})
   endtask
   initial begin
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      for (int i = 0; i < 4; i++) rdc(adr[i], 32'h0);
      for (int i = 0; i < 4; i++) begin
         apb(1'b1, adr[i], 32'hffffffff);
         rdc(adr[i], msk[i]);
      end
      apb(1'b0, 8'h14, 32'h0);
      `CHK({err, rd}, {1'b1, 32'h0})
      rdc(8'h10, 32'h0000_0001);
      $display("test registers done");
      // Address code used as on an external-extension system
      foreach (codes[k]) begin
         apb(1'b1, 8'h00, {16'h0, {4{1'b0, codes[k]}}});
         settle(8'h5a);
         chk_a(codes[k]);
         settle(8'ha5);
         chk_a(codes[k]);
      end
      $display("test port A done");
      apb(1'b1, 8'h04, 32'h000000a5);
      apb(1'b1, 8'h08, 32'h0);
      apb(1'b1, 8'h0c, 32'h0);
      settle(8'h3c);
      `CHK({b_oe, b_out & b_oe, b_gin}, {8'ha5, b_go & 8'ha5, pb_in})
      `CHK(b_oe_red, 8'ha4)
      apb(1'b1, 8'h08, 32'h00001100);
      apb(1'b1, 8'h0c, 32'h00001111);
      settle(8'hc3);
      `CHK(b_oe, {b_aoe[7:2], 2'b01})
      `CHK(b_out & b_oe, {b_ao[7:2], b_go[1:0]} & {b_aoe[7:2], 2'b01})
      `CHK(b_gin, pb_in & 8'h03)
      `CHK(b_oe_red, {b_aoe[7:2], 2'b00})
      $display("test port B done");
      @(posedge clk);
      strap <= 1'b1;
      nrst <= 1'b0;
      repeat (3) @(posedge clk);
      nrst <= 1'b1;
      repeat (2) @(posedge clk);
      rdc(8'h00, 32'h4444);
      rdc(8'h04, 32'h0);
      rdc(8'h10, 32'h0000_0001);
      $display("test boot strap done");
      test_done();
   end
endmodule
